// ==== logic/acr_regs.vh ====
// register map, field positions, reset values and counts for the converter control block
`ifndef ACR_REGS_VH
`define ACR_REGS_VH

// register select field carried in the top bits of a written word
`define ACR_SEL_HI 11
`define ACR_SEL_LO 10
`define ACR_SEL_CR0 2'h0
`define ACR_SEL_CR1 2'h1

// first control register fields
`define ACR_CR0_CHSEL0 3
`define ACR_CR0_CHSEL1 4
`define ACR_CR0_DIFF0 5
`define ACR_CR0_DIFF1 6
`define ACR_CR0_SCAN 7
`define ACR_CR0_TEST0 8
`define ACR_CR0_TEST1 9
`define ACR_CR0_RESET 10'h000

// second control register fields
`define ACR_CR1_SOFT_RESET 0
`define ACR_CR1_OVERRUN 1
`define ACR_CR1_TRIG_LO 2
`define ACR_CR1_TRIG_HI 3
`define ACR_CR1_STYLE 4
`define ACR_CR1_POLARITY 5
`define ACR_CR1_RW_MODE 6
`define ACR_CR1_FORMAT 7
`define ACR_CR1_OFFSET_CAL 8
`define ACR_CR1_ECHO 9
`define ACR_CR1_RESET 10'h030
// bits that act on write and are never stored
`define ACR_CR1_ACTION_MASK 10'h103

// cycles from reset until the first conversion may enter the queue
`define ACR_WARMUP_CYC 3'h5

// echo read sequence positions
`define ACR_ECHO_CR0 2'h0
`define ACR_ECHO_CR1 2'h1
`define ACR_ECHO_DONE 2'h2

// threshold tables, four 5-bit levels per channel count, code 0 in the low slot
`define ACR_TL_WIDTH 5
`define ACR_TL_1CH 20'h72081
`define ACR_TL_2CH 20'h62082
`define ACR_TL_3CH 20'h624c3
`define ACR_TL_4CH 20'h63104

`endif

// ==== logic/acr_mem.v ====
// sample queue storage with registered read data
module acr_mem #(
  parameter DW = 12,
  parameter AW = 4
) (
  input wire clock,
  input wire rst,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // read port follows the read pointer every cycle, so the head word is ready one cycle later
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= {DW{1'b0}};
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule // acr_mem

// ==== logic/acr_thresh.v ====
// queue fill threshold lookup from channel configuration and threshold code
`include "acr_regs.vh"

module acr_thresh (
  input wire [9:0] cr0,
  input wire [1:0] code,
  output reg [4:0] level
);

  // number of converted channels minus one; a differential pair counts as one
  function [1:0] chan_less_one;
    input [9:0] c;
    begin
      if (!c[`ACR_CR0_SCAN]) begin
        chan_less_one = 2'h0;
      end else begin
        case ({c[`ACR_CR0_DIFF1], c[`ACR_CR0_DIFF0], c[`ACR_CR0_CHSEL1], c[`ACR_CR0_CHSEL0]})
          4'h1: chan_less_one = 2'h1;
          4'h2: chan_less_one = 2'h2;
          4'h3: chan_less_one = 2'h3;
          4'h5: chan_less_one = 2'h1;
          4'h6: chan_less_one = 2'h2;
          4'h9: chan_less_one = 2'h1;
          default: chan_less_one = 2'h0;
        endcase
      end
    end
  endfunction

  reg [19:0] table_sel;

  always @* begin
    case (chan_less_one(cr0))
      2'h0: table_sel = `ACR_TL_1CH;
      2'h1: table_sel = `ACR_TL_2CH;
      2'h2: table_sel = `ACR_TL_3CH;
      default: table_sel = `ACR_TL_4CH;
    endcase
    level = table_sel[code*`ACR_TL_WIDTH +: `ACR_TL_WIDTH];
  end

endmodule // acr_thresh

// ==== logic/acr_ctrl.v ====
// converter second control register, sample queue and data-available logic
// Operation
// - bit 0 write resets registers, queue, offset
// - five cycles after reset before first sample
// - bit 1 read shows queue overrun
// - reading the register clears overrun
// - bit 1 write flushes the queue
// - bits 2-3 set threshold for ready flag
// - threshold table per channel count
// - differential or single input counts once
// - samples leave in fixed channel order
// - bit 4 picks level or pulse, reset one
// - bit 5 picks ready polarity, reset one
// - bit 6 set: write strobe becomes direction
// - bit 6 clear: separate read, write strobes
// - bit 7 picks two's complement or binary
// - bit 8 calibrates and subtracts offset
// - echo mode reads control 0 then 1
// - level flag drops on first read
// - pulse is half sample clock wide
`include "acr_regs.vh"

module acr_ctrl #(
  parameter DW = 12,
  parameter AW = 4
) (
  input wire clock,
  input wire rst,
  input wire cs0_n,
  input wire cs1,
  input wire rd_n,
  input wire wr_n,
  input wire [DW-1:0] data_in,
  output reg [DW-1:0] data_out,
  output reg data_oe_n,
  input wire sample_clock_in,
  input wire conv_valid,
  input wire [DW-1:0] conv_data,
  output reg zero_inputs,
  output reg samples_ready_flag,
  output reg fifo_overrun_flag
);

  // pin synchronisers; only the second stage is read
  reg [4:0] pin_m_r;
  reg [4:0] pin_s_r;
  reg [DW-1:0] din_m_r;
  reg [DW-1:0] din_s_r;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_m_r <= 5'h0d;
      pin_s_r <= 5'h0d;
      din_m_r <= {DW{1'b0}};
      din_s_r <= {DW{1'b0}};
    end else begin
      pin_m_r <= {sample_clock_in, wr_n, rd_n, cs1, cs0_n};
      pin_s_r <= pin_m_r;
      din_m_r <= data_in;
      din_s_r <= din_m_r;
    end
  end

  wire cs0_n_s = pin_s_r[0];
  wire cs1_s = pin_s_r[1];
  wire rd_n_s = pin_s_r[2];
  wire wr_n_s = pin_s_r[3];
  wire sclk_s = pin_s_r[4];

  reg [9:0] cr0_r;
  reg [9:0] cr1_r;
  reg srst_r;
  reg rd_d_r;
  reg wr_d_r;
  reg sclk_d_r;

  wire cs_act = ~cs0_n_s & cs1_s;
  wire rw_mode = cr1_r[`ACR_CR1_RW_MODE];
  wire rd_int;
  wire wr_int;

  assign rd_int = cs_act & (rw_mode ? wr_n_s : (~rd_n_s & wr_n_s));
  assign wr_int = cs_act & (rw_mode ? ~wr_n_s : (~wr_n_s & rd_n_s));

  wire rd_go = rd_int & ~rd_d_r;
  wire wr_go = wr_int & ~wr_d_r;
  wire sclk_rise = sclk_s & ~sclk_d_r;
  wire sclk_edge = sclk_s ^ sclk_d_r;

  wire [1:0] sel = din_s_r[`ACR_SEL_HI:`ACR_SEL_LO];
  wire wr_cr0 = wr_go & (sel == `ACR_SEL_CR0);
  wire wr_cr1 = wr_go & (sel == `ACR_SEL_CR1);
  wire soft_rst_req = wr_cr1 & din_s_r[`ACR_CR1_SOFT_RESET];
  wire flush_req = wr_cr1 & din_s_r[`ACR_CR1_OVERRUN];
  wire cal_req = wr_cr1 & din_s_r[`ACR_CR1_OFFSET_CAL];
  wire echo_on = cr1_r[`ACR_CR1_ECHO];

  // queue pointers carry one extra bit to tell full from empty
  reg [AW:0] wp_r;
  reg [AW:0] rp_r;
  wire [AW:0] fill = wp_r - rp_r;
  wire q_empty = (wp_r == rp_r);
  wire q_full = (fill[AW] == 1'b1);
  wire [DW-1:0] mem_q;

  reg [1:0] echo_cnt_r;
  wire echo_rd = echo_on & (echo_cnt_r != `ACR_ECHO_DONE);
  wire pop = rd_go & ~echo_rd & ~q_empty;
  wire cr1_read = rd_go & echo_on & (echo_cnt_r == `ACR_ECHO_CR1);

  reg [2:0] warm_r;
  wire warm_done = (warm_r == `ACR_WARMUP_CYC);
  reg cal_pend_r;
  reg [DW-1:0] offset_r;
  wire take = conv_valid & warm_done;

  wire [DW-1:0] corrected = conv_data - offset_r;
  wire [DW-1:0] formatted = cr1_r[`ACR_CR1_FORMAT] ?
    {~corrected[DW-1], corrected[DW-2:0]} : corrected;
  wire push = take & ~cal_pend_r & ~q_full;
  wire overrun_evt = take & ~cal_pend_r & q_full;

  // strobe edge history and soft reset pulse
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_d_r <= 1'b0;
      wr_d_r <= 1'b0;
      sclk_d_r <= 1'b0;
      srst_r <= 1'b0;
    end else begin
      rd_d_r <= rd_int;
      wr_d_r <= wr_int;
      sclk_d_r <= sclk_s;
      srst_r <= soft_rst_req;
    end
  end

  // control registers; action bits are not stored
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cr0_r <= `ACR_CR0_RESET;
      cr1_r <= `ACR_CR1_RESET;
      echo_cnt_r <= `ACR_ECHO_CR0;
    end else if (srst_r) begin
      cr0_r <= `ACR_CR0_RESET;
      cr1_r <= `ACR_CR1_RESET;
      echo_cnt_r <= `ACR_ECHO_CR0;
    end else begin
      if (wr_cr0) begin
        cr0_r <= din_s_r[9:0];
      end
      if (wr_cr1 & ~soft_rst_req) begin
        cr1_r <= din_s_r[9:0] & ~`ACR_CR1_ACTION_MASK;
        echo_cnt_r <= `ACR_ECHO_CR0;
      end else if (rd_go & echo_rd) begin
        echo_cnt_r <= echo_cnt_r + 2'h1;
      end
    end
  end

  // warm-up count, calibration and offset register
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      warm_r <= 3'h0;
      cal_pend_r <= 1'b0;
      offset_r <= {DW{1'b0}};
      zero_inputs <= 1'b0;
    end else if (srst_r) begin
      warm_r <= 3'h0;
      cal_pend_r <= 1'b0;
      offset_r <= {DW{1'b0}};
      zero_inputs <= 1'b0;
    end else begin
      if (!warm_done) begin
        warm_r <= warm_r + 3'h1;
      end
      if (cal_req) begin
        cal_pend_r <= 1'b1;
        zero_inputs <= 1'b1;
      end else if (take & cal_pend_r) begin
        offset_r <= conv_data;
        cal_pend_r <= 1'b0;
        zero_inputs <= 1'b0;
      end
    end
  end

  // queue pointers and overrun flag
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      wp_r <= {(AW+1){1'b0}};
      rp_r <= {(AW+1){1'b0}};
      fifo_overrun_flag <= 1'b0;
    end else if (srst_r | flush_req) begin
      wp_r <= {(AW+1){1'b0}};
      rp_r <= {(AW+1){1'b0}};
      // a sample that meets a full queue in the flush cycle still counts as an overrun
      fifo_overrun_flag <= overrun_evt & ~srst_r;
    end else begin
      if (push) begin
        wp_r <= wp_r + {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        rp_r <= rp_r + {{AW{1'b0}}, 1'b1};
      end
      if (overrun_evt) begin
        fifo_overrun_flag <= 1'b1;
      end else if (cr1_read) begin
        fifo_overrun_flag <= 1'b0;
      end
    end
  end

  acr_mem #(
    .DW(DW),
    .AW(AW)
  ) u_mem (
    .clock(clock),
    .rst(rst),
    .we(push),
    .waddr(wp_r[AW-1:0]),
    .wdata(formatted),
    .raddr(rp_r[AW-1:0]),
    .rdata(mem_q)
  );

  wire [4:0] level;

  // threshold from bits 2 and 3
  acr_thresh u_thresh (
    .cr0(cr0_r),
    .code(cr1_r[`ACR_CR1_TRIG_HI:`ACR_CR1_TRIG_LO]),
    .level(level)
  );

  // read data path: echo words first, then queue words
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      data_out <= {DW{1'b0}};
      data_oe_n <= 1'b1;
    end else begin
      data_oe_n <= ~rd_int;
      if (rd_go) begin
        if (echo_rd & (echo_cnt_r == `ACR_ECHO_CR0)) begin
          data_out <= {`ACR_SEL_CR0, cr0_r};
        end else if (echo_rd) begin
          data_out <= {`ACR_SEL_CR1, cr1_r[9:2], fifo_overrun_flag, 1'b0};
        end else begin
          data_out <= mem_q;
        end
      end
    end
  end

  // ready flag: armed until threshold met, re-armed after level-many reads
  reg armed_r;
  reg avail_r;
  reg [4:0] reads_left_r;
  wire pulse_style = cr1_r[`ACR_CR1_STYLE];
  // test modes silence the flag
  wire test_on = cr0_r[`ACR_CR0_TEST0] | cr0_r[`ACR_CR0_TEST1];
  // both sides widened to one size so any queue depth compares without truncation
  wire [AW+5:0] fill_wide = {5'h00, fill};
  wire [AW+5:0] level_wide = {{(AW+1){1'b0}}, level};
  wire met = armed_r & ~test_on & (fill_wide >= level_wide);
  // pulses start on a sample clock rise so they last exactly its high half
  wire fire = met & (pulse_style ? sclk_rise : 1'b1);

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      armed_r <= 1'b1;
      avail_r <= 1'b0;
      reads_left_r <= 5'h00;
    end else if (srst_r | flush_req) begin
      armed_r <= 1'b1;
      avail_r <= 1'b0;
      reads_left_r <= 5'h00;
    end else begin
      if (fire) begin
        avail_r <= 1'b1;
        armed_r <= 1'b0;
        reads_left_r <= level;
      end else begin
        if (pop & (reads_left_r != 5'h00)) begin
          reads_left_r <= reads_left_r - 5'h01;
          if (reads_left_r == 5'h01) begin
            armed_r <= 1'b1;
          end
        end
        if (~pulse_style & pop) begin
          avail_r <= 1'b0;
        end
        if (pulse_style & sclk_edge) begin
          avail_r <= 1'b0;
        end
        if (test_on) begin
          avail_r <= 1'b0;
        end
      end
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      samples_ready_flag <= 1'b0;
    end else begin
      samples_ready_flag <= avail_r ^ ~cr1_r[`ACR_CR1_POLARITY];
    end
  end

endmodule // acr_ctrl

// ==== sim/acr_ctrl_monitor.sv ====
// port assertions for the converter control block
module acr_mon #(
  parameter DW = 12,
  parameter AW = 4
) (
  input logic clock,
  input logic rst,
  input logic cs0_n,
  input logic conv_valid,
  input logic [DW-1:0] data_out,
  input logic data_oe_n,
  input logic zero_inputs,
  input logic samples_ready_flag,
  input logic fifo_overrun_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_reset_idle: assert property ($fell(rst) |-> (data_oe_n && !zero_inputs)[*3])
    else $error("bus or calibration active after reset");
  a_warmup_quiet: assert property (
    $fell(rst) |-> (!samples_ready_flag && !fifo_overrun_flag)[*6])
    else $error("queue activity during warm-up");
  a_ovf_cause: assert property ($rose(fifo_overrun_flag) |-> $past(conv_valid))
    else $error("overrun without a sample");
  a_ovf_holds: assert property (
    fifo_overrun_flag && cs0_n && $past(cs0_n) && $past(cs0_n, 2) && $past(cs0_n, 3)
    |=> fifo_overrun_flag)
    else $error("overrun lost without an access");
  a_cal_consumed: assert property (zero_inputs && conv_valid |=> !zero_inputs)
    else $error("calibration not finished by its sample");
  a_oe_needs_cs: assert property (
    !data_oe_n |-> !$past(cs0_n, 3) || !$past(cs0_n, 4))
    else $error("data driven without a select");
  a_oe_holds: assert property (!data_oe_n && !cs0_n && !$past(cs0_n) |=> !data_oe_n)
    else $error("data released while read held");
  a_dout_on_read: assert property ($changed(data_out) |-> $fell(data_oe_n))
    else $error("read word changed outside a read");
  c_read: cover property ($fell(data_oe_n));
  c_overrun: cover property ($rose(fifo_overrun_flag));
  c_cal: cover property ($fell(zero_inputs));
endmodule // acr_mon

bind acr_ctrl acr_mon #(.DW(DW), .AW(AW)) mon_u (.clock(clock), .rst(rst), .cs0_n(cs0_n),
  .conv_valid(conv_valid), .data_out(data_out), .data_oe_n(data_oe_n),
  .zero_inputs(zero_inputs), .samples_ready_flag(samples_ready_flag),
  .fifo_overrun_flag(fifo_overrun_flag));

// ==== sim/acr_host.sv ====
// host processor model on the parallel register bus
module acr_host (
  input logic clock,
  input logic data_oe_n,
  input logic [11:0] data_out,
  output logic cs0_n,
  output logic cs1,
  output logic rd_n,
  output logic wr_n,
  output logic [11:0] data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rwm = 1'b0;
  initial begin
    cs0_n = 1'b1;
    cs1 = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    data_in = 12'h000;
  end
  task automatic access(input logic rd, input logic [11:0] w, output logic [11:0] r);
    int n;
    n = 0;
    data_in = w;
    @(negedge clock);
    cs0_n = 1'b0;
    cs1 = 1'b1;
    if (rwm)
      wr_n = rd;
    else if (rd)
      rd_n = 1'b0;
    else
      wr_n = 1'b0;
    repeat (4) @(negedge clock);
    while (rd && data_oe_n !== 1'b0 && n < 20) begin
      @(negedge clock);
      n++;
    end
    r = data_out;
    cs0_n = 1'b1;
    cs1 = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    // inverted data after release so a stale word never looks valid
    data_in = ~w;
    repeat (3) @(negedge clock);
  endtask
endmodule // acr_host

// ==== sim/tb.sv ====
// self-checking bench for the converter control block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic sample_clock_in = 1'b0;
  logic conv_valid = 1'b0;
  logic [11:0] conv_data = 12'h000;
  logic cs0_n, cs1, rd_n, wr_n, data_oe_n, zero_inputs, samples_ready_flag, fifo_overrun_flag;
  logic [11:0] data_in, data_out, x, q[16];
  logic [31:0] seed = 32'h9f22, r, v, w;
  int miscompares = 0, n_compared = 0, n;
  logic [9:0] t_cr0 [9] = '{10'h0, 10'h0, 10'h0, 10'h0, 10'h88, 10'h90, 10'h98, 10'hc8, 10'h20};
  logic [1:0] t_code [9] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1, 2'h0, 2'h3};
  logic [4:0] t_lvl [9] = '{5'h1, 5'h4, 5'h8, 5'he, 5'hc, 5'h9, 5'h8, 5'h2, 5'he};
  acr_ctrl #(.DW(12), .AW(4)) dut_u (.clock(clock), .rst(rst), .cs0_n(cs0_n), .cs1(cs1),
    .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .sample_clock_in(sample_clock_in), .conv_valid(conv_valid), .conv_data(conv_data),
    .zero_inputs(zero_inputs), .samples_ready_flag(samples_ready_flag),
    .fifo_overrun_flag(fifo_overrun_flag));
  acr_host host_u (.clock(clock), .data_oe_n(data_oe_n), .data_out(data_out), .cs0_n(cs0_n),
    .cs1(cs1), .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [11:0] expw(logic [11:0] d, logic [11:0] o, logic f);
    return (d - o) ^ {f, 11'h000};
  endfunction
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t word %h exp %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t flag %b exp %b", $time, g, e);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wreg(input logic [11:0] d);
    logic [11:0] u;
    host_u.access(1'b0, d, u);
  endtask
  task automatic rreg(output logic [11:0] d);
    host_u.access(1'b1, 12'h000, d);
  endtask
  // warm-up after soft reset is waited out before any sample
  task automatic srst();
    wreg(12'h401);
    host_u.rwm = 1'b0;
    repeat (4) @(negedge clock);
  endtask
  task automatic push(input logic [31:0] d);
    @(negedge clock);
    conv_valid = 1'b1;
    conv_data = d[11:0];
    @(negedge clock);
    conv_valid = 1'b0;
    conv_data = ~d[11:0];
    @(negedge clock);
  endtask
  initial forever #25 clock = ~clock;
  initial forever begin
    repeat (4) @(negedge clock);
    sample_clock_in = ~sample_clock_in;
  end
  initial begin
    repeat (30000) @(posedge clock);
    miscompares++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    wrap_up();
  end
  initial begin
    repeat (8) @(negedge clock);
    rst = 1'b0;
    repeat (8) @(negedge clock);
    for (int i = 0; i < 9; i++) begin
      r = rnd();
      srst();
      wreg({2'h0, t_cr0[i]});
      wreg({2'h1, 2'h1, r[1], r[2], r[0], 1'b0, t_code[i], 2'h0});
      host_u.rwm = r[2];
      chkb(zero_inputs, 1'b1);
      v = rnd();
      push(v);
      chkb(zero_inputs, 1'b0);
      for (int k = 0; k < t_lvl[i]; k++) begin
        chkb(samples_ready_flag, ~r[0]);
        w = rnd();
        q[k] = w[11:0];
        push(w);
      end
      repeat (3) @(negedge clock);
      chkb(samples_ready_flag, r[0]);
      for (int k = 0; k < t_lvl[i]; k++) begin
        rreg(x);
        chk(x, expw(q[k], v[11:0], r[1]));
        chkb(samples_ready_flag, ~r[0]);
      end
      $display("threshold case %0d done", i);
    end
    srst();
    for (int j = 0; j < 2; j++) begin
      w = rnd();
      push(w);
      n = 0;
      repeat (40) begin
        @(negedge clock);
        n += samples_ready_flag;
      end
      chk(12'(n), 12'h004);
      rreg(x);
      chk(x, w[11:0]);
    end
    $display("pulse test done");
    srst();
    v = rnd();
    wreg({2'h0, v[9:0]});
    wreg(12'h630);
    repeat (17) push(rnd());
    chkb(fifo_overrun_flag, 1'b1);
    rreg(x);
    chk(x, {2'h0, v[9:0]});
    rreg(x);
    chk(x, 12'h632);
    chkb(fifo_overrun_flag, 1'b0);
    push(rnd());
    chkb(fifo_overrun_flag, 1'b1);
    wreg(12'h432);
    chkb(fifo_overrun_flag, 1'b0);
    w = rnd();
    push(w);
    rreg(x);
    chk(x, w[11:0]);
    srst();
    $display("echo test done");
    wrap_up();
  end
endmodule // tb
